// >>> bwhp_map.vh
// Purpose: constants for the byte-wide host port with dma handshakes
// Assumes: 125 MHz core clock
// Notes:   direct register indices and reset values
`ifndef BWHP_MAP_VH
`define BWHP_MAP_VH
// ==========================================================
// direct register indices on direct_reg_select
`define BWHP_REG_INDEX   2'h0
`define BWHP_REG_DATA    2'h1
`define BWHP_REG_STATUS  2'h2
`define BWHP_REG_PIO     2'h3
// ==========================================================
// reset values
`define BWHP_INDEX_RST   8'h00
`define BWHP_CTRL_RST    8'h00
// ==========================================================
// control register fields (indirect index 0)
`define BWHP_CTRL_PLAY_EN 0
`define BWHP_CTRL_CAP_EN  1
// ==========================================================
// status register fields
`define BWHP_ST_CAP_RDY   0
`define BWHP_ST_PLAY_RDY  1
`define BWHP_ST_INIT_DONE 2
// ==========================================================
// timing: init time in ms, cycles at 125 MHz (longest time, exact product of ms and kHz)
`define BWHP_CLK_KHZ      125000
`define BWHP_INIT_MS      512
`define BWHP_INIT_CYCLES  (`BWHP_INIT_MS * `BWHP_CLK_KHZ)
`endif

// >>> bwhp_fifo.v
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   storage in flip-flops, honest full and empty
`timescale 1ns/1ps
module bwhp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             srst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // occupancy
  output wire             full,
  output wire             empty
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // ==========================================================
  // flags
  assign full      = (cnt_q == DEPTH[AW:0]);
  assign empty     = (cnt_q == {(AW+1){1'b0}});
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;

  // pointers wrap at depth so non power of two depths also work
  always @(posedge clk) begin
    if (srst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // storage write, no reset needed on data
  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

// >>> bwhp_port.v
// Purpose: byte-wide asynchronous host port with capture/playback dma
// Assumes: strobes are unclocked pins, sampled through two flip-flops
// Notes:   transceiver controls follow the synchronised strobes
`timescale 1ns/1ps
`include "bwhp_map.vh"
module bwhp_port #(
  parameter DEPTH       = 16,
  parameter AW          = 4,
  parameter INIT_CYCLES = `BWHP_INIT_CYCLES
) (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  // host bus pins
  input  wire       rd_n,
  input  wire       wr_n,
  input  wire       cs_n,
  input  wire [1:0] direct_reg_select,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe,
  // dma handshake pins
  output reg        capture_request,
  input  wire       capture_ack_n,
  output reg        playback_request,
  input  wire       playback_ack_n,
  // external transceiver control
  output reg        transceiver_enable_n,
  output reg        transceiver_direction,
  // converter side: capture samples in, playback samples out
  input  wire       cap_valid,
  output reg        cap_ready,
  input  wire [7:0] cap_data,
  output reg        play_valid,
  input  wire       play_ready,
  output reg  [7:0] play_data
);
  // ==========================================================
  // synchronisers: meta stage read only by the second stage
  reg [4:0] pins_m_q;
  reg [4:0] pins_s_q;
  reg [9:0] bus_m_q;
  reg [9:0] bus_s_q;
  wire      s_rd;
  wire      s_wr;
  wire      s_cs;
  wire      s_cak;
  wire      s_pak;
  wire [1:0] s_sel;
  wire [7:0] s_din;

  always @(posedge clk) begin
    if (srst) begin
      pins_m_q <= 5'h1f;
      pins_s_q <= 5'h1f;
      bus_m_q  <= 10'h000;
      bus_s_q  <= 10'h000;
    end else begin
      pins_m_q <= {rd_n, wr_n, cs_n, capture_ack_n, playback_ack_n};
      pins_s_q <= pins_m_q;
      bus_m_q  <= {direct_reg_select, data_in};
      bus_s_q  <= bus_m_q;
    end
  end

  // active-high views of the synchronised pins
  assign s_rd  = ~pins_s_q[4];
  assign s_wr  = ~pins_s_q[3];
  assign s_cs  = ~pins_s_q[2];
  assign s_cak = ~pins_s_q[1];
  assign s_pak = ~pins_s_q[0];
  assign s_sel = bus_s_q[9:8];
  assign s_din = bus_s_q[7:0];

  // ==========================================================
  // cycle classification
  wire dma_rd;
  wire dma_wr;
  wire reg_rd;
  wire reg_wr;
  wire any_ack;
  wire any_cyc;

  assign any_ack = s_cak | s_pak;
  assign dma_rd  = s_rd & s_cak;
  assign dma_wr  = s_wr & s_pak;
  // cs only counts outside dma cycles
  assign reg_rd  = s_rd & s_cs & ~any_ack;
  assign reg_wr  = s_wr & s_cs & ~any_ack;
  // transceiver opens for a strobe with cs or with either ack
  assign any_cyc = (s_rd | s_wr) & (s_cs | any_ack);

  // strobe edge detectors act once per host strobe
  reg  rd_prev_q;
  reg  wr_prev_q;
  wire rd_fall;
  wire wr_rise;

  always @(posedge clk) begin
    if (srst) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= s_rd;
      wr_prev_q <= s_wr;
    end
  end

  assign rd_fall = s_rd & ~rd_prev_q;
  // write data is latched at the strobe's end, when it is surely set up
  assign wr_rise = ~s_wr & wr_prev_q;

  // remember cycle type of the write in flight
  reg wr_dma_q;
  reg wr_reg_q;

  always @(posedge clk) begin
    if (srst) begin
      wr_dma_q <= 1'b0;
      wr_reg_q <= 1'b0;
    end else if (s_wr) begin
      wr_dma_q <= dma_wr;
      wr_reg_q <= reg_wr;
    end
  end

  // ==========================================================
  // fifos: capture fills from converter, playback from host
  wire       capf_in_ready;
  wire       capf_out_valid;
  wire [7:0] capf_out_data;
  wire       capf_empty;
  wire       playf_in_ready;
  wire       playf_out_valid;
  wire [7:0] playf_out_data;
  wire       playf_full;
  wire       cap_pop;
  wire       play_push;
  wire       play_pop;
  reg        cap_push_q;
  reg  [7:0] cap_byte_q;

  // capture input stage registered so cap_ready is a flip-flop
  always @(posedge clk) begin
    if (srst) begin
      cap_push_q <= 1'b0;
      cap_byte_q <= 8'h00;
      cap_ready  <= 1'b0;
    end else begin
      cap_push_q <= cap_valid & cap_ready;
      cap_byte_q <= cap_data;
      // ready held low while an accepted sample is still in the staging register
      cap_ready  <= capf_in_ready & ~(cap_valid & cap_ready) & ~cap_push_q;
    end
  end

  assign cap_pop   = rd_fall & dma_rd;
  assign play_push = wr_rise & wr_dma_q;

  bwhp_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_cap_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (cap_push_q),
    .in_ready  (capf_in_ready),
    .in_data   (cap_byte_q),
    .out_valid (capf_out_valid),
    .out_ready (cap_pop),
    .out_data  (capf_out_data),
    .full      (),
    .empty     (capf_empty)
  );

  bwhp_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_play_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (play_push),
    .in_ready  (playf_in_ready),
    .in_data   (s_din),
    .out_valid (playf_out_valid),
    .out_ready (play_pop),
    .out_data  (playf_out_data),
    .full      (playf_full),
    .empty     ()
  );

  // playback output stage: one register, refilled when taken
  assign play_pop = playf_out_valid & (~play_valid | play_ready);

  always @(posedge clk) begin
    if (srst) begin
      play_valid <= 1'b0;
      play_data  <= 8'h00;
    end else if (play_pop) begin
      play_valid <= 1'b1;
      play_data  <= playf_out_data;
    end else if (play_ready) begin
      play_valid <= 1'b0;
    end
  end

  // ==========================================================
  // direct registers
  reg [7:0]  index_q;
  reg [7:0]  ctrl_q;
  reg [7:0]  pio_q;
  reg [31:0] init_cnt_q;
  reg        init_done_q;

  // power-up initialisation timer, counts down once after reset
  always @(posedge clk) begin
    if (srst) begin
      init_cnt_q  <= INIT_CYCLES;
      init_done_q <= 1'b0;
    end else if (init_cnt_q != 32'h0000_0000) begin
      init_cnt_q <= init_cnt_q - 32'h0000_0001;
    end else begin
      init_done_q <= 1'b1;
    end
  end

  // register writes at the end of the write strobe
  always @(posedge clk) begin
    if (srst) begin
      index_q <= `BWHP_INDEX_RST;
      ctrl_q  <= `BWHP_CTRL_RST;
      pio_q   <= 8'h00;
    end else if (wr_rise & wr_reg_q) begin
      if (s_sel == `BWHP_REG_INDEX) begin
        index_q <= s_din;
      end else if (s_sel == `BWHP_REG_DATA) begin
        if (index_q == 8'h00) begin
          ctrl_q <= s_din;
        end
      end else if (s_sel == `BWHP_REG_PIO) begin
        pio_q <= s_din;
      end
    end
  end

  // read mux for register cycles
  function [7:0] reg_read;
    input [1:0] sel;
    input [7:0] idx;
    input [7:0] ctl;
    input [7:0] st;
    input [7:0] pio;
    begin
      if (sel == `BWHP_REG_INDEX) begin
        reg_read = idx;
      end else if (sel == `BWHP_REG_DATA) begin
        reg_read = (idx == 8'h00) ? ctl : 8'h00;
      end else if (sel == `BWHP_REG_STATUS) begin
        reg_read = st;
      end else begin
        reg_read = pio;
      end
    end
  endfunction

  wire [7:0] status;
  assign status = {5'h00, init_done_q, ~playf_full, capf_out_valid};

  // ==========================================================
  // pin outputs, all registered
  wire req_cap_en;
  wire req_play_en;

  assign req_cap_en  = ctrl_q[`BWHP_CTRL_CAP_EN];
  assign req_play_en = ctrl_q[`BWHP_CTRL_PLAY_EN];

  always @(posedge clk) begin
    if (srst) begin
      capture_request       <= 1'b0;
      playback_request      <= 1'b0;
      transceiver_enable_n  <= 1'b1;
      transceiver_direction <= 1'b1;
      data_oe               <= 1'b0;
      data_out              <= 8'h00;
    end else begin
      capture_request  <= req_cap_en & ~capf_empty;
      playback_request <= req_play_en & playf_in_ready;
      // enable low only inside a strobe with cs or either ack
      transceiver_enable_n  <= ~any_cyc;
      // rests high, low only for device-to-host reads
      transceiver_direction <= ~(s_rd & (s_cs | any_ack));
      data_oe <= dma_rd | reg_rd;
      // dma byte captured at the read's start and held; register reads reload every clock
      if (rd_fall & dma_rd) begin
        data_out <= capf_out_valid ? capf_out_data : 8'h00;
      end else if (reg_rd) begin
        data_out <= reg_read(s_sel, index_q, ctrl_q, status, pio_q);
      end
    end
  end
endmodule

// >>> bwhp_checker.sv
// Purpose: pin-level checks of the host port
// Assumes: a pin reaches the outputs within 3 clocks
// Notes:   relations wait for 5 steady samples
`timescale 1ns/1ps
module bwhp_checker (
  // clock and reset
  input wire clk,
  input wire srst,
  // host pins
  input wire rd_n,
  input wire wr_n,
  input wire cs_n,
  input wire capture_ack_n,
  input wire playback_ack_n,
  // device outputs
  input wire data_oe,
  input wire capture_request,
  input wire playback_request,
  input wire transceiver_enable_n,
  input wire transceiver_direction
);
  // ==========================================================
  // cycle decode from the pins; an ack makes the cycle dma
  wire       sel_c = !cs_n || !capture_ack_n || !playback_ack_n;
  wire       en_c  = (!rd_n || !wr_n) && sel_c;
  wire       dir_c = !rd_n && sel_c;
  // reads that the port accepts and answers on the bus
  wire       rd_c  = !rd_n && (!capture_ack_n ||
                     (!cs_n && capture_ack_n && playback_ack_n));
  reg  [3:0] quiet_q;
  // clocks since a strobe was low; requests fall only near one
  always @(posedge clk) begin
    if (srst)
      quiet_q <= 4'hf;
    else if (!rd_n || !wr_n)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hf)
      quiet_q <= quiet_q + 4'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ==========================================================
  // transceiver, bus drive and request release
  en_on_a: assert property (en_c [*5] |-> !transceiver_enable_n)
    else $error("enable not low in cycle");
  en_off_a: assert property (!en_c [*5] |-> transceiver_enable_n)
    else $error("enable low outside cycle");
  dir_read_a: assert property (dir_c [*5] |-> !transceiver_direction)
    else $error("direction not low on read");
  dir_rest_a: assert property (!dir_c [*5] |-> transceiver_direction)
    else $error("direction low outside read");
  oe_read_a: assert property (rd_c [*5] |-> data_oe)
    else $error("bus not driven on read");
  oe_idle_a: assert property (!rd_c [*5] |-> !data_oe)
    else $error("bus driven outside read");
  oe_pair_a: assert property (data_oe |-> !transceiver_direction
    && !transceiver_enable_n) else $error("bus driven, transceiver off");
  cap_hold_a: assert property ($fell(capture_request) |-> quiet_q < 4'hc)
    else $error("capture request fell without a read");
  play_hold_a: assert property ($fell(playback_request) |-> quiet_q < 4'hc)
    else $error("playback request fell without a write");
  cover property (!capture_ack_n && !rd_n);
  cover property (!playback_ack_n && !wr_n);
  cover property ($fell(playback_request));
endmodule
bind bwhp_port bwhp_checker chk (
  .clk(clk), .srst(srst), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n),
  .capture_ack_n(capture_ack_n), .playback_ack_n(playback_ack_n),
  .data_oe(data_oe), .capture_request(capture_request),
  .playback_request(playback_request),
  .transceiver_enable_n(transceiver_enable_n),
  .transceiver_direction(transceiver_direction));

// >>> bwhp_host_model.sv
// Purpose: host bus and dma controller facing the port
// Assumes: strobes held 6 clocks, select and data held 3 after
// Notes:   a released data bus shows the inverse of its last value
`timescale 1ns/1ps
module bwhp_host_model (
  // clock
  input wire       clk,
  // host pins
  output reg       rd_n,
  output reg       wr_n,
  output reg       cs_n,
  output reg       capture_ack_n,
  output reg       playback_ack_n,
  output reg [1:0] direct_reg_select,
  output reg [7:0] data_in,
  input wire [7:0] data_out,
  input wire       data_oe,
  // read result, one clock pulse
  output reg       rd_done,
  output reg       rd_oe,
  output reg [7:0] rd_byte
);
  initial begin
    {rd_n, wr_n, cs_n, capture_ack_n, playback_ack_n} = 5'h1f;
    direct_reg_select = 2'h0;
    data_in = 8'h00;
    rd_done = 1'b0;
    rd_oe = 1'b0;
    rd_byte = 8'h00;
  end
  // ==========================================================
  // one strobe cycle; r picks read, c/ca/pa are the active-low pins
  task cyc(input r, input c, input ca, input pa,
           input [1:0] s, input [7:0] d);
    begin
      @(negedge clk);
      cs_n = c;
      capture_ack_n = ca;
      playback_ack_n = pa;
      direct_reg_select = s;
      data_in = r ? ~data_in : d;
      @(negedge clk);
      rd_n = !r;
      wr_n = r;
      repeat (6) @(negedge clk);
      rd_byte = data_out;
      rd_oe = data_oe;
      rd_done = r;
      rd_n = 1'b1;
      wr_n = 1'b1;
      @(negedge clk);
      rd_done = 1'b0;
      // hold select and data past the rising strobe
      repeat (2) @(negedge clk);
      {cs_n, capture_ack_n, playback_ack_n} = 3'h7;
      data_in = ~data_in;
    end
  endtask
endmodule

// >>> bwhp_port_test.sv
// Purpose: self-checking bench for the host port
// Assumes: init shortened to 20 clocks
// Notes:   read and playback bytes are checked in issue order
`timescale 1ns/1ps
module bwhp_port_test;
  localparam DEPTH = 16;
  reg        clk, srst, cap_valid, play_ready;
  reg  [7:0] cap_data, v;
  wire       rd_n, wr_n, cs_n, capture_ack_n, playback_ack_n;
  wire       data_oe, capture_request, playback_request, rd_done, rd_oe;
  wire       transceiver_enable_n, transceiver_direction;
  wire       cap_ready, play_valid;
  wire [1:0] direct_reg_select;
  wire [7:0] data_in, data_out, play_data, rd_byte;
  integer    err_total, comparisons, seed, n, k;
  reg  [8:0] rd_q[$];
  reg  [8:0] note;
  reg  [7:0] pl_q[$];
  bwhp_host_model h (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n),
    .capture_ack_n(capture_ack_n), .playback_ack_n(playback_ack_n),
    .direct_reg_select(direct_reg_select), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .rd_done(rd_done),
    .rd_oe(rd_oe), .rd_byte(rd_byte));
  bwhp_port #(.DEPTH(DEPTH), .AW(4), .INIT_CYCLES(20)) dut (.clk(clk),
    .srst(srst), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n),
    .direct_reg_select(direct_reg_select), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe),
    .capture_request(capture_request), .capture_ack_n(capture_ack_n),
    .playback_request(playback_request), .playback_ack_n(playback_ack_n),
    .transceiver_enable_n(transceiver_enable_n),
    .transceiver_direction(transceiver_direction),
    .cap_valid(cap_valid), .cap_ready(cap_ready), .cap_data(cap_data),
    .play_valid(play_valid), .play_ready(play_ready),
    .play_data(play_data));
  // ==========================================================
  // compare, report and close
  task chk8(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task chk1(input [63:0] nm, input e, input g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task stop_test;
    begin
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // a loop that used its whole bound is a hang
  task lim(input integer i, input integer b);
    if (i >= b) begin
      err_total = err_total + 1;
      stop_test;
    end
  endtask
  function [7:0] rnd8(input integer u);
    integer r;
    begin
      r = $random(seed);
      rnd8 = r[7:0];
    end
  endfunction
  task rd(input c, input ca, input [1:0] s, input [7:0] e);
    begin
      rd_q.push_back({1'b1, e});
      h.cyc(1'b1, c, ca, 1'b1, s, 8'h00);
    end
  endtask
  task wr(input c, input pa, input [1:0] s, input [7:0] d);
    begin
      if (!pa)
        pl_q.push_back(d);
      h.cyc(1'b0, c, 1'b1, pa, s, d);
    end
  endtask
  // ==========================================================
  // monitor: each result takes the oldest note
  always @(posedge clk) begin
    if (rd_done) begin
      note = rd_q.pop_front();
      chk1("readoe", note[8], rd_oe);
      if (note[8])
        chk8("read", note[7:0], rd_byte);
    end
    if (play_valid && play_ready)
      chk8("play", pl_q.pop_front(), play_data);
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {srst, cap_valid, play_ready, cap_data} = {3'h4, 8'h00};
    {err_total, comparisons, seed} = {32'd0, 32'd0, 32'd47983};
    repeat (3) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    rd(1'b0, 1'b1, 2'h2, 8'h02);
    repeat (30) @(negedge clk);
    rd(1'b0, 1'b1, 2'h2, 8'h06);
    // scratch writes; one without chip select must be ignored
    for (k = 0; k < 4; k = k + 1) begin
      v = rnd8(0);
      wr(1'b0, 1'b1, 2'h3, v);
      wr(1'b1, 1'b1, 2'h3, ~v);
      // unselected read: the port must leave the bus alone
      rd_q.push_back(9'h000);
      h.cyc(1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 8'h00);
      rd(1'b0, 1'b1, 2'h3, v);
    end
    wr(1'b0, 1'b1, 2'h0, 8'h00);
    wr(1'b0, 1'b1, 2'h1, 8'h03);
    rd(1'b0, 1'b1, 2'h1, 8'h03);
    chk1("preq", 1'b1, playback_request);
    chk1("creq", 1'b0, capture_request);
    // fill playback with the converter stalled; chip select is ignored
    // one clock more lets the request settle before it is looked at
    for (n = 0; playback_request === 1'b1 && n < 40; n = n + 1) begin
      wr(1'b0, 1'b0, 2'h3, rnd8(0));
      @(negedge clk);
    end
    lim(n, 40);
    // the output stage holds one byte beyond the fifo
    chk8("pfill", 8'(DEPTH + 1), n[7:0]);
    for (k = 0; pl_q.size() > 0 && k < 900; k = k + 1) begin
      @(negedge clk);
      play_ready = rnd8(0) > 8'h70;
    end
    lim(k, 900);
    @(negedge clk);
    play_ready = 1'b0;
    chk1("preq2", 1'b1, playback_request);
    // fill capture until it refuses; ready seen before the edge
    cap_valid = 1'b1;
    cap_data = rnd8(0);
    n = 0;
    for (k = 0; k < 80; k = k + 1) begin
      v = {7'h00, cap_ready};
      @(negedge clk);
      if (v[0] === 1'b1) begin
        rd_q.push_back({1'b1, cap_data});
        n = n + 1;
        cap_data = rnd8(0);
      end
    end
    cap_valid = 1'b0;
    chk1("capfull", 1'b0, cap_ready);
    chk1("creq2", 1'b1, capture_request);
    for (k = 0; capture_request === 1'b1 && k < 40; k = k + 1)
      h.cyc(1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 8'h00);
    lim(k, 40);
    chk8("cdrain", n[7:0], k[7:0]);
    rd(1'b1, 1'b0, 2'h0, 8'h00);
    stop_test;
  end
endmodule
